/* src/eeprom_pkg.sv */
package eeprom_pkg;
	// ****************************************
	// clock and link timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCL_QTR_NS = 40;
	localparam int SCL_QTR_CYCLES = SCL_QTR_NS / CLK_PERIOD_NS;
	localparam int WRITE_TIME_NS = 5000000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;

	// ****************************************
	// addressing and page layout
	// ****************************************
	localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
	localparam int ADDR_W = 13;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 32;
	localparam int MEM_BYTES = 8192;
	localparam logic [3:0] ACK_SLOT = 4'h8;
endpackage

/* src/twi_if.sv */
`timescale 1ns/10ps
`default_nettype none
// two-wire bus: every driver only pulls low while its enable is high
interface twi_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// wired-and of the open-drain drivers with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !(sda_m_oe && !sda_m_o) && !(sda_d_oe && !sda_d_o);

	modport master (
		output scl_o,
		output scl_oe,
		output sda_m_o,
		output sda_m_oe,
		input  scl,
		input  sda
	);
	modport dev (
		output sda_d_o,
		output sda_d_oe,
		input  scl,
		input  sda
	);
endinterface
`default_nettype wire

/* src/twi_master.sv */
`timescale 1ns/10ps
`default_nettype none
module twi_master (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// two-wire link
	twi_if.master           bus,
	// byte command port
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic       cmd_start,
	input  wire logic       cmd_stop,
	input  wire logic       cmd_read,
	input  wire logic       cmd_ack,
	input  wire logic [7:0] cmd_wdata,
	// byte answer port
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_nack
);
	typedef enum logic [3:0] {
		M_IDLE  = 4'h1,
		M_START = 4'h2,
		M_BIT   = 4'h4,
		M_STOP  = 4'h8
	} mstate_t;

	localparam int QTR = eeprom_pkg::SCL_QTR_CYCLES;

	mstate_t    st_q;
	logic [7:0] qcnt_q;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q;
	logic       stop_q;
	logic       read_q;
	logic       ack_q;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic [1:0] sda_sq;
	logic       tick;

	// ****************************************
	// pin sampling and quarter-bit divider
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			sda_sq <= 2'h3;
		end else begin
			sda_sq <= {sda_sq[0], bus.sda};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || st_q == M_IDLE || tick) begin
			qcnt_q <= 8'h00;
		end else begin
			qcnt_q <= qcnt_q + 8'h01;
		end
	end

	assign tick = (qcnt_q == 8'(QTR - 1));
	assign cmd_ready = (st_q == M_IDLE);

	// ****************************************
	// bus sequencer
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q      <= M_IDLE;
			ph_q      <= 2'h0;
			bit_q     <= 4'h0;
			sh_q      <= 8'h00;
			stop_q    <= 1'b0;
			read_q    <= 1'b0;
			ack_q     <= 1'b0;
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data  <= 8'h00;
			rsp_nack  <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (st_q == M_IDLE) begin
				if (cmd_valid) begin
					st_q   <= cmd_start ? M_START : M_BIT;
					ph_q   <= 2'h0;
					bit_q  <= 4'h0;
					sh_q   <= cmd_wdata;
					stop_q <= cmd_stop;
					read_q <= cmd_read;
					ack_q  <= cmd_ack;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				unique case (st_q)
					M_START: begin
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b0;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b1;
							2'h3: begin
								scl_oe_q <= 1'b1;
								st_q     <= M_BIT;
							end
						endcase
					end
					M_BIT: begin
						unique case (ph_q)
							2'h0: sda_oe_q <= (bit_q == 4'h8) ?
								(read_q && ack_q) :
								(!read_q && !sh_q[7]);
							2'h1: scl_oe_q <= 1'b0;
							2'h2: begin
								if (bit_q == 4'h8) begin
									rsp_nack <= sda_sq[1];
								end else begin
									sh_q <= {sh_q[6:0], sda_sq[1]};
								end
							end
							2'h3: begin
								scl_oe_q <= 1'b1;
								if (bit_q == 4'h8) begin
									rsp_valid <= 1'b1;
									rsp_data  <= sh_q;
									st_q <= stop_q ? M_STOP : M_IDLE;
								end else begin
									bit_q <= bit_q + 4'h1;
								end
							end
						endcase
					end
					M_STOP: begin
						unique case (ph_q)
							2'h0: sda_oe_q <= 1'b1;
							2'h1: scl_oe_q <= 1'b0;
							2'h2: sda_oe_q <= 1'b0;
							2'h3: st_q <= M_IDLE;
						endcase
					end
					M_IDLE: ;
				endcase
			end
		end
	end

	// open-drain drive: enable high pulls the line low
	assign bus.scl_o   = 1'b0;
	assign bus.scl_oe  = scl_oe_q;
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = sda_oe_q;
endmodule
`default_nettype wire

/* src/eeprom_slave.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - up to 32 bytes buffered, committed at Stop
// - write increments only low five pointer bits
// - over 32 bytes wraps and overwrites buffer
// - Stop after write data starts write cycle
// - protected write acked, nothing written, stays ready
// - master keeps page writes inside one page
// - write-protect high blocks whole array
// - write-protect sampled at Stop only
// - busy cycle suppresses control byte acknowledge
// - master polls with write control bytes
// - direction bit one selects read
// - pointer holds last access plus one
// - read acks then shifts out eight bits
// - address loads pointer, no write without data
// - random read leaves pointer past read byte
// - master ack requests next sequential byte
// - full pointer increments after each read byte
// - pointer rolls from top to zero
// - control byte carries type code and selects
// - two address bytes, high first, thirteen used
// - nack from master releases data line
module eeprom_slave #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// two-wire link
	twi_if.dev        bus,
	// straps and protection pins
	input  wire logic chip_select_strap_2,
	input  wire logic chip_select_strap_1,
	input  wire logic chip_select_strap_0,
	input  wire logic write_protect,
	// status
	output logic      write_busy
);
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_CTRL = 6'h02,
		ST_ADDH = 6'h04,
		ST_ADDL = 6'h08,
		ST_WR   = 6'h10,
		ST_RD   = 6'h20
	} dstate_t;

	localparam int AW = eeprom_pkg::ADDR_W;
	localparam int PW = eeprom_pkg::PAGE_W;
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

	// ****************************************
	// storage and state
	// ****************************************
	logic [7:0]       mem_q [eeprom_pkg::MEM_BYTES];
	logic [7:0]       buf_q [eeprom_pkg::PAGE_BYTES];
	logic [31:0]      valid_q;
	dstate_t          state_q;
	logic [3:0]       bitcnt_q;
	logic [7:0]       shift_q;
	logic [4:0]       addr_hi_q;
	logic [AW-1:0]    ptr_q;
	logic [7:0]       tx_q;
	logic             sda_oe_q;
	logic             got_data_q;
	logic             busy_q;
	logic             commit_q;
	logic [PW-1:0]    cidx_q;
	logic [CNT_W-1:0] wcnt_q;
	logic [2:0]       scl_sq;
	logic [2:0]       sda_sq;
	logic [1:0]       wp_sq;
	logic [2:0]       cs_s1_q;
	logic [2:0]       cs_s2_q;
	logic             scl_rise;
	logic             scl_fall;
	logic             start_c;
	logic             stop_c;
	logic             sel_match;

	// ****************************************
	// pin synchronisers and bus conditions
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_sq  <= 3'h7;
			sda_sq  <= 3'h7;
			wp_sq   <= 2'h0;
			cs_s1_q <= 3'h0;
			cs_s2_q <= 3'h0;
		end else begin
			scl_sq  <= {scl_sq[1:0], bus.scl};
			sda_sq  <= {sda_sq[1:0], bus.sda};
			wp_sq   <= {wp_sq[0], write_protect};
			cs_s1_q <= {chip_select_strap_2, chip_select_strap_1,
				chip_select_strap_0};
			cs_s2_q <= cs_s1_q;
		end
	end

	// edges seen on the second and third stages only
	assign scl_rise = scl_sq[1] && !scl_sq[2];
	assign scl_fall = !scl_sq[1] && scl_sq[2];
	assign start_c  = scl_sq[1] && scl_sq[2] && !sda_sq[1] && sda_sq[2];
	assign stop_c   = scl_sq[1] && scl_sq[2] && sda_sq[1] && !sda_sq[2];
	assign sel_match = (shift_q[7:4] == eeprom_pkg::DEV_TYPE_CODE) &&
		(shift_q[3:1] == cs_s2_q);

	// ****************************************
	// command decoder and bit engine
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			bitcnt_q   <= 4'h0;
			shift_q    <= 8'h00;
			addr_hi_q  <= 5'h00;
			ptr_q      <= '0;
			tx_q       <= 8'h00;
			sda_oe_q   <= 1'b0;
			got_data_q <= 1'b0;
			valid_q    <= 32'h0;
		end else if (start_c) begin
			state_q    <= ST_CTRL;
			bitcnt_q   <= 4'h0;
			sda_oe_q   <= 1'b0;
			got_data_q <= 1'b0;
			if (!busy_q) begin
				valid_q <= 32'h0;
			end
		end else if (stop_c) begin
			state_q    <= ST_IDLE;
			sda_oe_q   <= 1'b0;
			got_data_q <= 1'b0;
		end else if (scl_rise) begin
			if (bitcnt_q == eeprom_pkg::ACK_SLOT) begin
				bitcnt_q <= 4'h0;
				// acknowledge slot driven by the master
				if (state_q == ST_RD && !sda_oe_q) begin
					ptr_q <= ptr_q + 13'h0001;
					if (sda_sq[1]) begin
						state_q <= ST_IDLE;
					end else begin
						tx_q <= mem_q[ptr_q + 13'h0001];
					end
				end
			end else begin
				shift_q  <= {shift_q[6:0], sda_sq[1]};
				bitcnt_q <= bitcnt_q + 4'h1;
			end
		end else if (scl_fall) begin
			// release by default, covers master ack slot
			sda_oe_q <= 1'b0;
			if (bitcnt_q == eeprom_pkg::ACK_SLOT) begin
				unique case (state_q)
					ST_CTRL: begin
						if (sel_match && !busy_q) begin
							sda_oe_q <= 1'b1;
							if (shift_q[0]) begin
								state_q <= ST_RD;
								tx_q    <= mem_q[ptr_q];
							end else begin
								state_q <= ST_ADDH;
							end
						end else begin
							state_q <= ST_IDLE;
						end
					end
					ST_ADDH: begin
						addr_hi_q <= shift_q[4:0];
						sda_oe_q  <= 1'b1;
						state_q   <= ST_ADDL;
					end
					ST_ADDL: begin
						ptr_q    <= {addr_hi_q, shift_q};
						sda_oe_q <= 1'b1;
						state_q  <= ST_WR;
					end
					ST_WR: begin
						buf_q[ptr_q[PW-1:0]]   <= shift_q;
						valid_q[ptr_q[PW-1:0]] <= 1'b1;
						ptr_q[PW-1:0] <= ptr_q[PW-1:0] + 5'h01;
						got_data_q    <= 1'b1;
						sda_oe_q      <= 1'b1;
					end
					ST_RD, ST_IDLE: ;
				endcase
			end else if (state_q == ST_RD) begin
				// idle after nack leaves line high
				sda_oe_q <= !tx_q[3'h7 - bitcnt_q[2:0]];
			end
		end
	end

	// ****************************************
	// self-timed write cycle
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			busy_q   <= 1'b0;
			commit_q <= 1'b0;
			cidx_q   <= '0;
			wcnt_q   <= '0;
		end else if (stop_c && state_q == ST_WR && got_data_q &&
				!wp_sq[1]) begin
			// protect sampled at this stop only
			busy_q   <= 1'b1;
			commit_q <= 1'b1;
			cidx_q   <= '0;
			wcnt_q   <= '0;
		end else if (busy_q) begin
			if (commit_q) begin
				cidx_q <= cidx_q + 5'h01;
				if (cidx_q == 5'h1f) begin
					commit_q <= 1'b0;
				end
			end
			wcnt_q <= wcnt_q + CNT_W'(1);
			if (wcnt_q == CNT_W'(WRITE_CYCLES - 1)) begin
				busy_q <= 1'b0;
			end
		end
	end

	// copy buffered bytes into the current page
	always_ff @(posedge mclk) begin
		if (commit_q && valid_q[cidx_q]) begin
			mem_q[{ptr_q[AW-1:PW], cidx_q}] <= buf_q[cidx_q];
		end
	end

	// ****************************************
	// pin drive and status
	// ****************************************
	assign bus.sda_d_o  = 1'b0;
	assign bus.sda_d_oe = sda_oe_q;
	assign write_busy   = busy_q;
endmodule
`default_nettype wire

/* bench/eeprom_props.sv */
`timescale 1ns/10ps
`default_nettype none
module eeprom_props #(
	parameter int WRITE_CYCLES = 200
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// watched lines and pins
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_oe,
	input wire logic write_protect,
	input wire logic write_busy
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic [31:0] cnt_q;

	// ****************************************
	// helper counter
	// ****************************************
	// length of the running write cycle
	always_ff @(posedge mclk) begin
		if (rst || !write_busy)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_q + 32'h1;
	end
	sequence busy_run;
		write_busy [*8];
	endsequence
	sequence bus_idle;
		scl && sda;
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	// quiet while busy
	a_busy_quiet: assert property (write_busy |-> !sda_d_oe)
		else $error("device drives data while busy");
	a_busy_min: assert property ($rose(write_busy) |=> busy_run)
		else $error("write cycle too short");
	a_busy_span: assert property ($fell(write_busy) |->
		cnt_q == WRITE_CYCLES) else $error("write cycle length wrong");
	a_wp_blocks: assert property ($rose(write_busy) |->
		!$past(write_protect, 3)) else $error("write cycle under protect");
	a_busy_at_stop: assert property ($rose(write_busy) |-> bus_idle)
		else $error("write cycle began with bus active");
	a_drive_low: assert property ($rose(sda_d_oe) |-> !scl)
		else $error("device drive began with clock high");
	a_release_low: assert property ($fell(sda_d_oe) |-> !scl)
		else $error("device released with clock high");
	a_start_free: assert property (scl && $past(scl) && $fell(sda)
		|-> !sda_d_oe) else $error("device drives data at start");
endmodule
`default_nettype wire

/* bench/serial_eeprom_access_logic_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_access_logic_tb;
	localparam int WCYC = 200;
	localparam logic [2:0] SEL = 3'h5;
	localparam logic [7:0] CW = {eeprom_pkg::DEV_TYPE_CODE, SEL, 1'b0};
	localparam logic [7:0] CR = {eeprom_pkg::DEV_TYPE_CODE, SEL, 1'b1};
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       cmd_valid = 1'b0;
	logic       cmd_start = 1'b0;
	logic       cmd_stop = 1'b0;
	logic       cmd_read = 1'b0;
	logic       cmd_ack = 1'b0;
	logic [7:0] cmd_wdata = 8'h00;
	logic       cmd_ready;
	logic       rsp_valid;
	logic       rsp_nack;
	logic [7:0] rsp_data;
	logic       write_protect = 1'b0;
	logic       write_busy;
	logic [7:0] rd_q;
	logic       nack_q;
	int         error_cnt = 0;
	int         checked = 0;

	// ****************************************
	// clock, ends and checker
	// ****************************************
	always #(eeprom_pkg::CLK_PERIOD_NS / 2) mclk = !mclk;
	twi_if twi_if_i ();
	twi_master twi_master_i (.mclk(mclk), .rst(rst), .bus(twi_if_i),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start),
		.cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_ack(cmd_ack),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack));
	eeprom_slave #(.WRITE_CYCLES(WCYC)) eeprom_slave_i (.mclk(mclk),
		.rst(rst), .bus(twi_if_i), .chip_select_strap_2(SEL[2]),
		.chip_select_strap_1(SEL[1]), .chip_select_strap_0(SEL[0]),
		.write_protect(write_protect), .write_busy(write_busy));
	eeprom_props #(.WRITE_CYCLES(WCYC)) eeprom_props_i (.mclk(mclk),
		.rst(rst), .scl(twi_if_i.scl), .sda(twi_if_i.sda),
		.sda_d_oe(twi_if_i.sda_d_oe), .write_protect(write_protect),
		.write_busy(write_busy));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// waits until the sequencer is idle again
	task automatic wait_ready;
		int n;
		n = 0;
		@(negedge mclk);
		while (cmd_ready !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		check({7'h0, n == 400}, 8'h00);
	endtask
	// one byte on the link, answer kept in rd_q and nack_q
	task automatic xfer(input logic s, p, r, a, input logic [7:0] d);
		int n;
		wait_ready();
		{cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_wdata} = {s, p, r, a, d};
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		check({7'h0, n == 400}, 8'h00);
		rd_q = rsp_data;
		nack_q = rsp_nack;
	endtask
	task automatic addr(input logic [15:0] a);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, CW);
		check({7'h0, nack_q}, 8'h00);
		xfer(1'b0, 1'b0, 1'b0, 1'b0, a[15:8]);
		xfer(1'b0, 1'b0, 1'b0, 1'b0, a[7:0]);
	endtask
	// callers keep data inside one page, except the page test
	task automatic wr(input logic [15:0] a, input int n, input logic [7:0] b);
		addr(a);
		for (int i = 0; i < n; i++)
			xfer(1'b0, i == n - 1, 1'b0, 1'b0, b + 8'(i));
		wait_ready();
	endtask
	// polls until acked, returns number of refused polls
	task automatic poll(output int k);
		k = 0;
		nack_q = 1'b1;
		while (nack_q !== 1'b0 && k < 10) begin
			xfer(1'b1, 1'b1, 1'b0, 1'b0, CW);
			k += int'(nack_q);
		end
		check({7'h0, nack_q}, 8'h00);
	endtask
	// random read of one byte at a with last-byte nack
	task automatic rd1(input logic [15:0] a, input logic [7:0] exp);
		addr(a);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, CR);
		xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
		check(rd_q, exp);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_page;
		int k;
		wr(16'h0040, 34, 8'h10);
		poll(k);
		check({7'h0, k > 0}, 8'h01);
		addr(16'h0040);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, CR);
		for (int i = 0; i < 32; i++) begin
			xfer(1'b0, i == 31, 1'b1, i != 31, 8'h00);
			check(rd_q, (i < 2) ? 8'h30 + 8'(i) : 8'h10 + 8'(i));
		end
		rd1(16'h0044, 8'h14);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, CR);
		xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
		check(rd_q, 8'h15);
		$display("t_page done");
	endtask
	task automatic t_protect;
		int k;
		write_protect = 1'b1;
		wr(16'h0045, 1, 8'hee);
		repeat (10) @(negedge mclk);
		check({7'h0, write_busy}, 8'h00);
		xfer(1'b1, 1'b1, 1'b0, 1'b0, CW);
		check({7'h0, nack_q}, 8'h00);
		rd1(16'h0045, 8'h15);
		write_protect = 1'b0;
		wr(16'h0100, 1, 8'h5a);
		repeat (10) @(negedge mclk);
		write_protect = 1'b1;
		poll(k);
		rd1(16'h0100, 8'h5a);
		write_protect = 1'b0;
		$display("t_protect done");
	endtask
	task automatic t_wrap;
		int k;
		wr(16'he000, 1, 8'ha5);
		poll(k);
		wr(16'hffff, 1, 8'h3c);
		poll(k);
		addr(16'hffff);
		xfer(1'b1, 1'b0, 1'b0, 1'b0, CR);
		xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
		check(rd_q, 8'h3c);
		xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
		check(rd_q, 8'ha5);
		xfer(1'b1, 1'b1, 1'b0, 1'b0, {eeprom_pkg::DEV_TYPE_CODE, ~SEL, 1'b0});
		check({7'h0, nack_q}, 8'h01);
		$display("t_wrap done");
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		t_page();
		t_protect();
		t_wrap();
		end_of_test();
	end
	initial begin
		#(eeprom_pkg::CLK_PERIOD_NS * 60000);
		error_cnt++;
		end_of_test();
	end
endmodule
`default_nettype wire
